/* File: apfc_defs.vh */
// Offsets, field positions, reset values and timing counts for the port block
`ifndef APFC_DEFS_VH
`define APFC_DEFS_VH

`define APFC_IDX_FMT      8'h28
`define APFC_IDX_OFS      8'h29
`define APFC_IDX_ROUTE    8'h2a
`define APFC_IDX_PROG     8'h2b
`define APFC_IDX_LOSS     8'h2c
`define APFC_IDX_IGNORE   8'h2d
`define APFC_IDX_STATUS   8'h2e

`define APFC_FMT_MSB      5
`define APFC_FMT_LSB      4
`define APFC_LEN_MSB      1
`define APFC_LEN_LSB      0
`define APFC_PATHL_MSB    5
`define APFC_PATHL_LSB    4
`define APFC_PATHR_MSB    1
`define APFC_PATHR_LSB    0

`define APFC_FMT_RST      2'h0
`define APFC_LEN_RST      2'h2
`define APFC_OFS_RST      8'h00
`define APFC_PATH_RST     2'h1
`define APFC_PROG_RST     5'h01
`define APFC_LOSS_RST     3'h0

`define APFC_FMT_I2S      2'h0
`define APFC_FMT_DSP      2'h1
`define APFC_FMT_RJ       2'h2
`define APFC_FMT_LJ       2'h3

`define APFC_PATH_MUTE    2'h0
`define APFC_PATH_SAME    2'h1
`define APFC_PATH_SWAP    2'h2

`define APFC_CLK_HZ       25000000
`define APFC_SECOND_S     1
`define APFC_SECOND_CYC   (`APFC_SECOND_S * `APFC_CLK_HZ)

`define APFC_RESP_OKAY    2'h0
`define APFC_RESP_SLVERR  2'h2

`endif

/* File: apfc_sync.v */
// Two-flop synchroniser for the audio clock pins
`timescale 1ns/1ps
module apfc_sync (
  input  wire clk,
  input  wire rstn,
  input  wire din,
  output wire dout
);
  reg stage1_r;
  reg stage2_r;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;
endmodule

/* File: apfc_loss_timer.v */
// Missing-clock timer: counts low time of both audio clocks
`timescale 1ns/1ps
`include "apfc_defs.vh"
module apfc_loss_timer #(
  parameter [31:0] SECOND_CYC = `APFC_SECOND_CYC
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       bitClkS,
  input  wire       frameClkS,
  input  wire [2:0] periodCode,
  output reg        missing_r
);
  reg [31:0] tickCnt_r;
  reg [3:0]  secCnt_r;
  wire       anyHigh;
  wire       tickDone;
  wire [3:0] secTarget;

  assign anyHigh   = bitClkS | frameClkS;
  assign tickDone  = (tickCnt_r == SECOND_CYC - 32'h1);
  assign secTarget = {1'b0, periodCode} + 4'h1;

  // Runs on clk, never on the audio clocks, so it keeps time when they stop
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_r <= 32'h0;
      secCnt_r  <= 4'h0;
      missing_r <= 1'b0;
    end else if (anyHigh) begin
      tickCnt_r <= 32'h0;
      secCnt_r  <= 4'h0;
      missing_r <= 1'b0;
    end else if (!missing_r) begin
      if (tickDone) begin
        tickCnt_r <= 32'h0;
        if (secCnt_r + 4'h1 >= secTarget) begin
          missing_r <= 1'b1;
        end else begin
          secCnt_r <= secCnt_r + 4'h1;
        end
      end else begin
        tickCnt_r <= tickCnt_r + 32'h1;
      end
    end
  end
endmodule

/* File: apfc_audio_port.v */
// Serial audio port format, routing and clock-loss supervision, AXI4-Lite
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "apfc_defs.vh"
module apfc_audio_port #(
  parameter [31:0] SECOND_CYC = `APFC_SECOND_CYC
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bitClk,
  input  wire        frameClk,
  input  wire        serialData,
  output reg  [1:0]  frameFormat_r,
  output reg  [1:0]  sampleWidth_r,
  output reg  [7:0]  sampleBitOffset_r,
  output reg  [31:0] leftPathSample_r,
  output reg  [31:0] rightPathSample_r,
  output reg         sampleStrobe_r,
  output reg  [4:0]  programSelect_r,
  output reg         converterPowerdown_r
);
  // Control registers
  reg  [1:0]  leftPathSource_r;
  reg  [1:0]  rightPathSource_r;
  reg  [2:0]  clockLossPeriod_r;
  reg         ignoreClockLoss_r;

  // Write channel holding
  reg  [7:0]  wrIdx_r;
  reg         awHeld_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg         wHeld_r;

  // Receiver state
  reg         bitClkPrev_r;
  reg         frameClkPrev_r;
  reg  [8:0]  bitCnt_r;
  reg  [31:0] shift_r;
  reg  [31:0] rxLeft_r;
  reg  [31:0] rxRight_r;
  reg         dataSync1_r;
  reg         dataSync2_r;
  reg         slotLeft_r;
  wire [31:0] shiftNxt;

  wire        bitClkS;
  wire        frameClkS;
  wire        missing;
  wire        bitRise;
  wire        frameEdge;
  wire        frameStart;
  wire        curLeft;
  wire [5:0]  wordBits;
  wire [8:0]  firstBit;
  wire [8:0]  lastBit;
  wire        doWrite;

  // Maps byte address to register index; 0xff marks misaligned addresses or addresses above 0x3ff
  function [7:0] regIndex;
    input [31:0] addr;
    begin
      if (addr[31:10] != 22'h0 || addr[1:0] != 2'h0)
        regIndex = 8'hff;
      else
        regIndex = addr[9:2];
    end
  endfunction

  function isMapped;
    input [7:0] idx;
    begin
      isMapped = (idx >= `APFC_IDX_FMT) && (idx <= `APFC_IDX_STATUS);
    end
  endfunction

  // Converter path steering from a received pair
  function [31:0] routeSample;
    input [1:0]  sel;
    input [31:0] same;
    input [31:0] other;
    begin
      case (sel)
        `APFC_PATH_SAME: routeSample = same;
        `APFC_PATH_SWAP: routeSample = other;
        default:         routeSample = 32'h0;
      endcase
    end
  endfunction

  apfc_sync uSyncBit (
    .clk  (clk),
    .rstn (rstn),
    .din  (bitClk),
    .dout (bitClkS)
  );

  apfc_sync uSyncFrame (
    .clk  (clk),
    .rstn (rstn),
    .din  (frameClk),
    .dout (frameClkS)
  );

  apfc_loss_timer #(
    .SECOND_CYC (SECOND_CYC)
  ) uLossTimer (
    .clk        (clk),
    .rstn       (rstn),
    .bitClkS    (bitClkS),
    .frameClkS  (frameClkS),
    .periodCode (clockLossPeriod_r),
    .missing_r  (missing)
  );

  // AXI4-Lite write path: address and data accepted in either order
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      wrIdx_r       <= 8'h0;
      wData_r       <= 32'h0;
      wStrb_r       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `APFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wrIdx_r       <= regIndex(s_axi_awaddr);
        awHeld_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r      <= s_axi_wdata;
        wStrb_r      <= s_axi_wstrb;
        wHeld_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(wrIdx_r) && wrIdx_r != `APFC_IDX_STATUS ?
                        `APFC_RESP_OKAY : `APFC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register file; only byte lane 0 carries the 8-bit registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frameFormat_r     <= `APFC_FMT_RST;
      sampleWidth_r     <= `APFC_LEN_RST;
      sampleBitOffset_r <= `APFC_OFS_RST;
      leftPathSource_r  <= `APFC_PATH_RST;
      rightPathSource_r <= `APFC_PATH_RST;
      programSelect_r   <= `APFC_PROG_RST;
      clockLossPeriod_r <= `APFC_LOSS_RST;
      ignoreClockLoss_r <= 1'b0;
    end else if (doWrite && wStrb_r[0]) begin
      case (wrIdx_r)
        `APFC_IDX_FMT: begin
          frameFormat_r <= wData_r[`APFC_FMT_MSB:`APFC_FMT_LSB];
          sampleWidth_r <= wData_r[`APFC_LEN_MSB:`APFC_LEN_LSB];
        end
        `APFC_IDX_OFS:    sampleBitOffset_r <= wData_r[7:0];
        `APFC_IDX_ROUTE: begin
          leftPathSource_r  <= wData_r[`APFC_PATHL_MSB:`APFC_PATHL_LSB];
          rightPathSource_r <= wData_r[`APFC_PATHR_MSB:`APFC_PATHR_LSB];
        end
        // Reserved program codes are stored as written
        `APFC_IDX_PROG:   programSelect_r <= wData_r[4:0];
        `APFC_IDX_LOSS:   clockLossPeriod_r <= wData_r[2:0];
        `APFC_IDX_IGNORE: ignoreClockLoss_r <= wData_r[0];
        default: begin
        end
      endcase
    end
  end

  // AXI4-Lite read path, one-cycle answer
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `APFC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= isMapped(regIndex(s_axi_araddr)) ?
                       `APFC_RESP_OKAY : `APFC_RESP_SLVERR;
      case (regIndex(s_axi_araddr))
        `APFC_IDX_FMT:
          s_axi_rdata <= {26'h0, frameFormat_r, 2'h0, sampleWidth_r};
        `APFC_IDX_OFS:    s_axi_rdata <= {24'h0, sampleBitOffset_r};
        `APFC_IDX_ROUTE:
          s_axi_rdata <= {26'h0, leftPathSource_r, 2'h0, rightPathSource_r};
        `APFC_IDX_PROG:   s_axi_rdata <= {27'h0, programSelect_r};
        `APFC_IDX_LOSS:   s_axi_rdata <= {29'h0, clockLossPeriod_r};
        `APFC_IDX_IGNORE: s_axi_rdata <= {31'h0, ignoreClockLoss_r};
        `APFC_IDX_STATUS:
          s_axi_rdata <= {30'h0, converterPowerdown_r, missing};
        default:          s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Powerdown follows the missing flag unless ignored
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      converterPowerdown_r <= 1'b0;
    else
      converterPowerdown_r <= missing && !ignoreClockLoss_r;
  end

  // Receiver framing
  assign wordBits = (sampleWidth_r == 2'h0) ? 6'd16 :
                    (sampleWidth_r == 2'h1) ? 6'd20 :
                    (sampleWidth_r == 2'h2) ? 6'd24 : 6'd32;
  assign bitRise   = bitClkS && !bitClkPrev_r;
  assign frameEdge = frameClkS != frameClkPrev_r;
  // DSP marks a frame by a rising pulse; others by each frame clock edge
  assign frameStart = (frameFormat_r == `APFC_FMT_DSP) ?
                      (frameClkS && !frameClkPrev_r) : frameEdge;
  // I2S carries left while the frame clock is low, DSP always takes left, others when high
  assign curLeft = (frameFormat_r == `APFC_FMT_I2S) ? !frameClkS :
                   (frameFormat_r == `APFC_FMT_DSP) ? 1'b1 : frameClkS;
  // I2S adds its one-bit delay on top of the programmed offset
  assign firstBit = {1'b0, sampleBitOffset_r} +
                    ((frameFormat_r == `APFC_FMT_I2S) ? 9'd1 : 9'd0);
  assign lastBit  = firstBit + {3'h0, wordBits} - 9'd1;
  assign shiftNxt = {shift_r[30:0], dataSync2_r};

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitClkPrev_r      <= 1'b0;
      frameClkPrev_r    <= 1'b0;
      dataSync1_r       <= 1'b0;
      dataSync2_r       <= 1'b0;
      bitCnt_r          <= 9'h1ff;
      shift_r           <= 32'h0;
      rxLeft_r          <= 32'h0;
      rxRight_r         <= 32'h0;
      leftPathSample_r  <= 32'h0;
      rightPathSample_r <= 32'h0;
      sampleStrobe_r    <= 1'b0;
      slotLeft_r        <= 1'b0;
    end else begin
      bitClkPrev_r   <= bitClkS;
      dataSync1_r    <= serialData;
      dataSync2_r    <= dataSync1_r;
      sampleStrobe_r <= 1'b0;
      if (bitRise) begin
        // Frame clock taken at bit clock rise; host moves it off that edge
        frameClkPrev_r <= frameClkS;
        if (frameStart) begin
          bitCnt_r   <= 9'h1;
          slotLeft_r <= curLeft;
        end else if (bitCnt_r != 9'h1ff) begin
          bitCnt_r <= bitCnt_r + 9'h1;
        end
        // Old slot count still runs here: an I2S word ends past the edge
        if ((bitCnt_r >= firstBit && bitCnt_r <= lastBit) ||
            (frameStart && firstBit == 9'h0))
          shift_r <= shiftNxt;
        if (bitCnt_r == lastBit) begin
          // Left-aligned word, short words padded with zeros
          if (slotLeft_r)
            rxLeft_r <= shiftNxt << (6'd32 - wordBits);
          else
            rxRight_r <= shiftNxt << (6'd32 - wordBits);
        end
      end
      if (bitRise && frameStart && !curLeft) begin
        leftPathSample_r  <= routeSample(leftPathSource_r,
                                         rxLeft_r, rxRight_r);
        rightPathSample_r <= routeSample(rightPathSource_r,
                                         rxRight_r, rxLeft_r);
        sampleStrobe_r    <= 1'b1;
      end
    end
  end
endmodule

/* File: apfc_audio_port_sva.sv */
// Checker for bus answers, field updates and clock-loss output
`timescale 1ns/1ps
`include "apfc_defs.vh"
module apfc_audio_port_sva #(
  parameter [31:0] SECOND_CYC = `APFC_SECOND_CYC
) (
  input wire        clk,
  input wire        rstn,
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        bitClk,
  input wire        frameClk,
  input wire [1:0]  frameFormat_r,
  input wire [1:0]  sampleWidth_r,
  input wire [7:0]  sampleBitOffset_r,
  input wire [4:0]  programSelect_r,
  input wire        converterPowerdown_r
);
  reg  [31:0] wrData_r;
  reg  [31:0] lowCnt_r;
  wire        wrTake;
  wire        arTake;
  assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                  && s_axi_wready;
  assign arTake = s_axi_arvalid && s_axi_arready;
  // Raw pin low time; saturates so a long idle never wraps
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrData_r <= 32'h0;
      lowCnt_r <= 32'h0;
    end else begin
      if (wrTake) wrData_r <= s_axi_wdata;
      if (bitClk || frameClk) lowCnt_r <= 32'h0;
      else if (lowCnt_r < 32'hffff) lowCnt_r <= lowCnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wrTo(a); wrTake && s_axi_awaddr == a && s_axi_wstrb[0]; endsequence
  sequence s_wrDone; ##[1:2] s_axi_bvalid; endsequence
  property p_wrAnswer; wrTake |-> s_wrDone; endproperty
  a_wrAnswer: assert property (p_wrAnswer) else $error("write unanswered");
  property p_rdAnswer; arTake |=> s_axi_rvalid; endproperty
  a_rdAnswer: assert property (p_rdAnswer) else $error("read unanswered");
  property p_rdUnmapped;
    arTake && s_axi_araddr == 32'hc0 |=> s_axi_rresp == `APFC_RESP_SLVERR;
  endproperty
  a_rdUnmapped: assert property (p_rdUnmapped) else $error("no read error");
  property p_fmtWrite; s_wrTo(32'ha0) |-> s_wrDone ##0
    (frameFormat_r == wrData_r[5:4] && sampleWidth_r == wrData_r[1:0]);
  endproperty
  a_fmtWrite: assert property (p_fmtWrite) else $error("format");
  property p_ofsWrite; s_wrTo(32'ha4) |-> s_wrDone ##0
    sampleBitOffset_r == wrData_r[7:0]; endproperty
  a_ofsWrite: assert property (p_ofsWrite) else $error("offset");
  property p_progWrite; s_wrTo(32'hac) |-> s_wrDone ##0
    programSelect_r == wrData_r[4:0]; endproperty
  a_progWrite: assert property (p_progWrite) else $error("program");
  property p_lossTime;
    $rose(converterPowerdown_r) && lowCnt_r > 8 |-> lowCnt_r >= SECOND_CYC;
  endproperty
  a_lossTime: assert property (p_lossTime) else $error("early");
  property p_clockBack;
    bitClk || frameClk |-> ##[1:6] !converterPowerdown_r;
  endproperty
  a_clockBack: assert property (p_clockBack) else $error("stuck");
endmodule
bind apfc_audio_port apfc_audio_port_sva #(.SECOND_CYC(SECOND_CYC)) chk (.*);

/* File: apfc_host.sv */
// Host audio source: I2S framing on bit clock, frame clock and data
`timescale 1ns/1ps
module apfc_host (
  output reg bitClk,
  output reg frameClk,
  output reg serialData
);
  integer    k;
  reg [63:0] word;
  reg        prevBit;
  initial begin
    bitClk = 1'b0;
    frameClk = 1'b0;
    serialData = 1'b1;
    prevBit = 1'b0;
  end
  // Clocks stand still between frames, low unless a test says otherwise
  task idle(input lvl);
    bitClk = lvl;
    frameClk = lvl;
  endtask
  // Odd start delay keeps the bit clock out of phase with the system clock
  task frame(input [31:0] l, input [31:0] r);
    word = {l, r};
    #7;
    for (k = 0; k < 64; k = k + 1) begin
      frameClk = (k >= 32);
      serialData = (k == 0) ? prevBit : word[64 - k];
      #160 bitClk = 1'b1;
      #160 bitClk = 1'b0;
    end
    prevBit = word[0];
    serialData = ~word[0];
    frameClk = 1'b0;
  endtask
endmodule

/* File: apfc_tb.sv */
// Bench: register map, path routing and clock-loss powerdown
`timescale 1ns/1ps
`include "apfc_defs.vh"
module tb;
  localparam SC = 20;
  localparam [47:0] RST = 48'h000001110002;
  localparam [47:0] MSK = 48'h01071f33ff33;
  reg         clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d, l, r;
  reg  [3:0]  s_axi_wstrb;
  reg  [7:0]  val [0:5];
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, bitClk, frameClk, serialData, sampleStrobe_r;
  wire        converterPowerdown_r;
  wire [1:0]  s_axi_bresp, s_axi_rresp, frameFormat_r, sampleWidth_r;
  wire [31:0] s_axi_rdata, leftPathSample_r, rightPathSample_r;
  wire [7:0]  sampleBitOffset_r;
  wire [4:0]  programSelect_r;
  integer     fail_count = 0, check_count = 0, cyc = 0, i, j, n;
  integer     strobes = 0;
  apfc_audio_port #(.SECOND_CYC(SC)) uut (.*);
  apfc_host host (.*);
  task chk(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr(input [31:0] a, input [31:0] x, input [3:0] s, input [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge clk);
    while (!(s_axi_awready && s_axi_wready)) @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge clk);
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
    @(posedge clk);
  endtask
  task rd(input [31:0] a, input [31:0] x, input [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (!s_axi_arready) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    while (!s_axi_rvalid) @(posedge clk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, x);
    chk(s_axi_rresp, e);
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    if (sampleStrobe_r === 1'b1) strobes = strobes + 1;
    cyc = cyc + 1;
    if (cyc == 30000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    d = $urandom(28976);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({frameFormat_r, sampleWidth_r}, 4'h2);
    for (i = 0; i < 6; i = i + 1) begin
      val[i] = RST[8 * i +: 8];
      rd(32'ha0 + 4 * i, val[i], `APFC_RESP_OKAY);
    end
    // Random fields, every format and width; strobe 1110 writes nothing
    for (j = 0; j < 8; j = j + 1) begin
      for (i = 0; i < 6; i = i + 1) begin
        d = $urandom;
        if (i == 0) d[5:0] = {j[1:0], 2'h0, ~j[1:0]};
        if (i == 1 && j < 2) d[7:0] = {8{j[0]}};
        if (i == 2) d[5:0] = (j % 3 == 0) ? 6'h02 : (j % 3 == 1) ? 6'h10 : 6'h21;
        wr(32'ha0 + 4 * i, d, (j == 3) ? 4'he : 4'hf, `APFC_RESP_OKAY);
        if (j != 3) val[i] = d[7:0] & MSK[8 * i +: 8];
        rd(32'ha0 + 4 * i, val[i], `APFC_RESP_OKAY);
      end
      chk({frameFormat_r, sampleWidth_r}, {val[0][5:4], val[0][1:0]});
      chk({sampleBitOffset_r, programSelect_r}, {val[1], val[3][4:0]});
    end
    rd(32'hc0, 32'h0, `APFC_RESP_SLVERR);
    wr(32'hb8, 32'h3, 4'hf, `APFC_RESP_SLVERR);
    wr(32'ha0, 32'h3, 4'hf, `APFC_RESP_OKAY);
    wr(32'ha4, 32'h0, 4'hf, `APFC_RESP_OKAY);
    wr(32'hb4, 32'h1, 4'hf, `APFC_RESP_OKAY);
    for (j = 0; j < 3; j = j + 1) begin
      wr(32'ha8, {j[1:0], 2'h0, j[1:0]}, 4'hf, `APFC_RESP_OKAY);
      l = $urandom;
      r = $urandom;
      n = strobes;
      repeat (3) host.frame(l, r);
      repeat (8) @(posedge clk);
      chk(strobes - n, 3);
      chk(leftPathSample_r, (j == 0) ? 0 : (j == 1) ? l : r);
      chk(rightPathSample_r, (j == 0) ? 0 : (j == 1) ? r : l);
    end
    wr(32'hb0, 32'h1, 4'hf, `APFC_RESP_OKAY);
    wr(32'hb4, 32'h0, 4'hf, `APFC_RESP_OKAY);
    host.frame(l, r);
    chk(converterPowerdown_r, 0);
    n = 0;
    while (!converterPowerdown_r && n < 200) begin
      @(posedge clk);
      n = n + 1;
    end
    chk(n >= 2 * SC && n <= 2 * SC + 8, 1);
    wr(32'hb4, 32'h1, 4'hf, `APFC_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(converterPowerdown_r, 0);
    host.idle(1'b1);
    wr(32'hb4, 32'h0, 4'hf, `APFC_RESP_OKAY);
    repeat (100) @(posedge clk);
    chk(converterPowerdown_r, 0);
    conclude;
  end
endmodule
